// File: testbench/ir_remote_command_receiver_tb.sv
// self-checking bench for the infrared command receiver
`timescale 1ns/1ns
module ir_remote_command_receiver_tb;
    import ir_rx_pkg::*;
    localparam int HOLD = 3;
    localparam int LIMIT = 80000;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic ir_in_n, pready, pslverr, irq, pairing_indication;
    logic unpairing_indication, paired = 1'b0, msk = 1'b0;
    logic [13:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd = '0, st = '0, cmd = '0, cfg = '0;
    logic [7:0] pid = '0;
    logic [6:0] key = '0;
    int error_cnt = 0, comparisons = 0, cycles = 0, seed = 5;
    int pair_seen = 0, unpair_seen = 0;
    ir_remote_command_receiver #(.HOLD_COUNT(HOLD), .INDICATE_CYC(100),
        .GAP_LIMIT(4000), .TIME_DIV(2000)) dut (.clock(clock),
        .reset_n(reset_n),
        .clock_enable(1'b1), .ir_in_n(ir_in_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .pairing_indication(pairing_indication),
        .unpairing_indication(unpairing_indication));
    ir_remote_model #(.TIME_DIV(2000)) remote (.clock(clock),
        .ir_in_n(ir_in_n));
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (pairing_indication === 1'b1) pair_seen++;
        if (unpairing_indication === 1'b1) unpair_seen++;
        if (cycles == LIMIT) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : compare
    task automatic apb(input logic w, input logic [11:0] idx,
                       input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        compare(rd, exp);
    endtask : rd_chk
    // reference model of one press; reps above zero is a hold
    task automatic press(input logic [7:0] id, input logic [6:0] k,
                         input int reps);
        remote.own_id = id;
        remote.hold(k, reps);
        if (!paired || id == 8'h00 || id == pid) begin
            st[EV_CMD] = 1'b1;
            cmd = {17'h0, id, k};
        end
        if (reps > 0 && k == KEY_RIGHT) begin
            paired = 1'b1;
            pid = id;
            st[EV_PAIR] = 1'b1;
            cfg = 32'h1;
        end else if (reps > 0 && paired) begin
            paired = 1'b0;
            st[EV_UNPAIR] = 1'b1;
            cfg = 32'h0;
        end
    endtask : press
    // bad-frame bit is left out: its setting on discarded frames is open
    task automatic check_all();
        compare({31'h0, irq}, {31'h0, msk & (|st[2:0])});
        rd_chk(IDX_REMOTE_CMD, cmd);
        rd_chk(IDX_CONFIG_FLAGS, cfg);
        apb(1'b0, IDX_SHORT_PRESS, 32'h0);
        compare(rd & ~32'h8, st);
        st = 32'h0;
        @(posedge clock);
        compare({31'h0, irq}, 32'h0);
    endtask : check_all
    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk(IDX_SHORT_PRESS, 32'h0);
        rd_chk(IDX_PAIRED_ID, 32'h0);
        apb(1'b1, 12'h0ff, $random(seed));
        rd_chk(12'h0ff, 32'h0);
        apb(1'b1, IDX_CONFIG_FLAGS, 32'h1);
        rd_chk(IDX_CONFIG_FLAGS, 32'h0);
        apb(1'b1, IDX_IRQ_MASK, 32'h7);
        msk = 1'b1;
        key = 7'($random(seed));
        press(8'h03, key, 0);
        check_all();
        remote.send(key, 5'h0d);
        check_all();
        remote.level(1'b0, 2000);
        remote.level(1'b1, 600);
        check_all();
        press(8'h03, KEY_RIGHT, HOLD);
        compare({31'h0, pair_seen > 0}, 32'h1);
        rd_chk(IDX_PAIRED_ID, 32'h3);
        check_all();
        press(8'h05, KEY_MENU, 0);
        check_all();
        apb(1'b1, IDX_IRQ_MASK, 32'h0);
        msk = 1'b0;
        press(8'h00, 7'h05, 0);
        check_all();
        apb(1'b1, IDX_IRQ_MASK, 32'h7);
        msk = 1'b1;
        press(8'h03, KEY_LEFT, HOLD);
        compare({31'h0, unpair_seen > 0}, 32'h1);
        check_all();
        press(8'h05, 7'h06, 0);
        check_all();
        press(8'h05, KEY_RIGHT, HOLD);
        apb(1'b1, IDX_CONFIG_FLAGS, 32'h0);
        cfg = 32'h0;
        check_all();
        print_verdict();
    end
endmodule : ir_remote_command_receiver_tb
bind ir_remote_command_receiver ir_rx_asserts #(.INDICATE_CYC(INDICATE_CYC))
    chk (.clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
    .ir_in_n(ir_in_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .pairing_indication(pairing_indication),
    .unpairing_indication(unpairing_indication));

// File: testbench/ir_remote_model.sv
// behavioural handheld remote driving the demodulated ir line
`timescale 1ns/1ns
module ir_remote_model
    import ir_rx_pkg::*;
#(
    parameter logic [7:0] MAKER = 8'h5a,
    parameter int TIME_DIV = 1
) (
    input wire logic clock,
    output logic ir_in_n
);
    logic [7:0] own_id = 8'h00;
    initial ir_in_n = 1'b1;
    // low is a mark; the line idles high between marks
    task automatic level(input logic v, input int us);
        ir_in_n <= v;
        repeat ((us * CLK_MHZ) / TIME_DIV) @(posedge clock);
    endtask : level
    task automatic tail();
        level(1'b0, 560);
        level(1'b1, 600);
    endtask : tail
    task automatic send(input logic [6:0] key, input logic [4:0] page);
        logic [31:0] f;
        f = {~{1'b0, key}, 1'b0, key, page, own_id[2:0], MAKER};
        @(posedge clock);
        level(1'b0, 9000);
        level(1'b1, 4500);
        for (int i = 0; i < 32; i++) begin
            level(1'b0, 560);
            level(1'b1, f[i] ? 1690 : 560);
        end
        tail();
    endtask : send
    task automatic hold(input logic [6:0] key, input int reps);
        send(key, SUPPORTED_PAGE);
        repeat (reps) begin
            level(1'b0, 9000);
            level(1'b1, 2250);
            tail();
        end
        if (reps > 0 && key == KEY_CENTER) own_id = own_id + 8'h01;
    endtask : hold
endmodule : ir_remote_model

// File: testbench/ir_rx_asserts.sv
// concurrent checks on the receiver ports
`timescale 1ns/1ns
module ir_rx_asserts
    import ir_rx_pkg::*;
#(
    parameter int INDICATE_CYC = 100
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire logic ir_in_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic pairing_indication,
    input wire logic unpairing_indication
);
    logic [10:0] idle_cnt;
    logic [15:0] pair_cnt;
    logic quiet;
    logic acc;
    // quiet means no mark for long enough that no frame can still be decoding
    assign quiet = idle_cnt[10];
    assign acc = psel && penable && clock_enable;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) idle_cnt <= '0;
        else if (!ir_in_n) idle_cnt <= '0;
        else if (!quiet) idle_cnt <= idle_cnt + 11'h001;
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) pair_cnt <= '0;
        else pair_cnt <= pairing_indication ? pair_cnt + 16'h0001 : '0;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_RDATA_HOLD: assert property (acc && !pwrite |=> $stable(prdata))
        else $error("read data moved after the access");
    AST_NO_ERROR: assert property (acc |-> !pslverr)
        else $error("error response on a register access");
    AST_MASK_OFF: assert property (acc && pwrite &&
        paddr[13:2] == IDX_IRQ_MASK && pwdata == 32'h0 |=> !irq)
        else $error("interrupt high with an empty mask");
    AST_STATUS_CLR: assert property (acc && !pwrite &&
        paddr[13:2] == IDX_SHORT_PRESS && quiet |=> !irq)
        else $error("interrupt stays after status read");
    AST_IRQ_CAUSE: assert property ($rose(irq) |->
        !quiet || $past(acc && pwrite))
        else $error("interrupt without frame or write");
    AST_PAIR_CAUSE: assert property ($rose(pairing_indication) |-> !quiet)
        else $error("pairing shown without ir traffic");
    AST_PAIR_MIN: assert property ($rose(pairing_indication) |=>
        pairing_indication [*8])
        else $error("pairing indication too short");
    AST_PAIR_MAX: assert property (pair_cnt <= INDICATE_CYC + 2)
        else $error("pairing indication too long");
    AST_UNPAIR_MIN: assert property ($rose(unpairing_indication) |=>
        unpairing_indication [*8])
        else $error("unpairing indication too short");
    COV_IRQ: cover property ($rose(irq));
    COV_PAIR: cover property ($rose(pairing_indication));
    COV_UNPAIR: cover property ($rose(unpairing_indication));
endmodule : ir_rx_asserts

// File: verilog/ir_pulse_timer.sv
// saturating duration counter for ir mark and space lengths
`timescale 1ns/1ns
module ir_pulse_timer #(
    parameter int WIDTH = 25
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic restart,
    output logic [WIDTH-1:0] count
);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (enable) begin
            if (restart) begin
                count <= '0;
            end else if (count != '1) begin
                count <= count + 1'b1;
            end
        end
    end
endmodule : ir_pulse_timer

// File: verilog/ir_remote_command_receiver.sv
// infrared remote command receiver with pairing and apb registers
// What this block does
// - accept only maker code and page 0xe
// - set command flag on accepted command
// - store button and remote id at 32
// - basic remote bypasses the pairing filter
// - while paired accept only matching id
// - menu+right 6s stores id, sets flag
// - show pairing indication after pairing
// - unpair by software clear or menu+left
// - show unpairing indication after menu+left unpairing
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
module ir_remote_command_receiver
    import ir_rx_pkg::*;
#(
    // arbitrary neutral maker code
    parameter logic [7:0] MAKER_CODE = 8'h5a,
    parameter logic [7:0] BASIC_ID = 8'h00,
    parameter int HOLD_COUNT = HOLD_REPEATS,
    parameter int INDICATE_CYC = 250000000,
    parameter int GAP_LIMIT = GAP_CYC,
    // divides every pulse threshold so that short benches can scale time
    parameter int TIME_DIV = 1
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire logic ir_in_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic pairing_indication,
    output logic unpairing_indication
);
    logic rst_meta_n;
    logic rst_n;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    logic ce;
    assign ce = clock_enable;
    logic mark;
    assign mark = ~ir_in_n;
    logic mark_q;
    rx_state_t state;
    logic [24:0] dur;
    logic [5:0] bit_cnt;
    logic [31:0] shift;
    logic edge_seen;
    assign edge_seen = mark ^ mark_q;

    ir_pulse_timer #(.WIDTH(25)) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .enable(ce),
        .restart(edge_seen),
        .count(dur)
    );

    // one-cycle results of the decoder
    logic frame_done;
    logic repeat_done;
    logic frame_bad;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mark_q <= 1'b0;
            state <= ST_IDLE;
            bit_cnt <= 6'h00;
            shift <= 32'h0000_0000;
            frame_done <= 1'b0;
            repeat_done <= 1'b0;
            frame_bad <= 1'b0;
        end else if (ce) begin
            mark_q <= mark;
            frame_done <= 1'b0;
            repeat_done <= 1'b0;
            frame_bad <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (mark) begin
                        state <= ST_LEAD_MARK;
                    end
                end
                ST_LEAD_MARK: begin
                    if (!mark) begin
                        if (dur >= 25'(LEAD_MARK_CYC / TIME_DIV)) begin
                            state <= ST_LEAD_SPACE;
                        end else begin
                            state <= ST_IDLE;
                            frame_bad <= 1'b1;
                        end
                    end
                end
                ST_LEAD_SPACE: begin
                    if (mark) begin
                        bit_cnt <= 6'h00;
                        if (dur >= 25'(LEAD_SPACE_CYC / TIME_DIV)) begin
                            state <= ST_BIT_MARK;
                        end else if (dur <= 25'(REP_SPACE_CYC / TIME_DIV)) begin
                            state <= ST_STOP;
                            bit_cnt <= 6'h3f;
                        end else begin
                            state <= ST_IDLE;
                            frame_bad <= 1'b1;
                        end
                    end
                end
                ST_BIT_MARK: begin
                    if (!mark) begin
                        state <= (bit_cnt == 6'd32) ? ST_STOP : ST_BIT_SPACE;
                    end
                end
                ST_BIT_SPACE: begin
                    if (mark) begin
                        // lsb first, distance gives the bit value
                        shift <= {dur >= 25'(BIT_ONE_CYC / TIME_DIV),
                                  shift[31:1]};
                        bit_cnt <= bit_cnt + 6'h01;
                        state <= ST_BIT_MARK;
                    end else if (dur >= 25'(LEAD_SPACE_CYC / TIME_DIV)) begin
                        state <= ST_IDLE;
                        frame_bad <= 1'b1;
                    end
                end
                ST_STOP: begin
                    if (!mark) begin
                        state <= ST_IDLE;
                        if (bit_cnt == 6'h3f) begin
                            repeat_done <= 1'b1;
                        end else begin
                            frame_done <= 1'b1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // frame layout: maker byte, page/id byte, command byte, inverted command
    logic [7:0] f_maker;
    logic [7:0] f_cmd;
    logic [7:0] f_cmd_n;
    logic [7:0] f_id;
    logic [4:0] f_page;
    assign f_maker = shift[7:0];
    assign f_id = shift[15:8];
    assign f_cmd = shift[23:16];
    assign f_cmd_n = shift[31:24];
    assign f_page = {1'b0, shift[CMD_PAGE_LSB+3:CMD_PAGE_LSB]};

    logic check_ok;
    assign check_ok = (f_cmd == ~f_cmd_n);
    logic frame_ok;
    assign frame_ok = frame_done && check_ok && (f_maker == MAKER_CODE)
                      && (f_page == SUPPORTED_PAGE);

    logic paired;
    logic [7:0] paired_id;
    logic [7:0] rx_id;
    // id rides in the three bits below the page field
    assign rx_id = {5'h00, f_id[2:0]};
    logic basic_remote;
    assign basic_remote = (rx_id == BASIC_ID);
    logic id_match;
    assign id_match = !paired || basic_remote || (rx_id == paired_id);
    logic accept;
    assign accept = frame_ok && id_match;

    remote_cmd_t remote_cmd;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            remote_cmd <= '0;
        end else if (ce && accept) begin
            remote_cmd <= '{remote_id: rx_id, button: f_cmd[6:0]};
        end
    end

    // hold tracking: last raw frame and repeat count
    logic [6:0] held_key;
    logic [7:0] held_id;
    logic [7:0] rep_cnt;
    logic hold_fired;
    logic [24:0] gap;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            held_key <= 7'h00;
            held_id <= 8'h00;
            rep_cnt <= 8'h00;
            gap <= 25'h0;
        end else if (ce) begin
            if (frame_ok) begin
                held_key <= f_cmd[6:0];
                held_id <= rx_id;
                rep_cnt <= 8'h00;
                gap <= 25'h0;
            end else if (repeat_done) begin
                if (rep_cnt != 8'hff) begin
                    rep_cnt <= rep_cnt + 8'h01;
                end
                gap <= 25'h0;
            end else if (gap >= 25'(GAP_LIMIT)) begin
                rep_cnt <= 8'h00;
            end else begin
                gap <= gap + 25'h1;
            end
        end
    end
    assign hold_fired = repeat_done && (rep_cnt == 8'(HOLD_COUNT - 1));

    // a combination is sent as the second key's code repeated; the remote
    // reports combos as the second key, and menu is implied by the combo
    logic do_pair;
    logic do_unpair;
    assign do_pair = hold_fired && (held_key == KEY_RIGHT)
                     && (held_id != BASIC_ID);
    assign do_unpair = hold_fired && (held_key == KEY_LEFT);

    // apb decode
    logic [11:0] idx;
    assign idx = word_index(paddr);
    logic wr_en;
    logic rd_en;
    assign wr_en = psel && penable && pwrite && ce;
    assign rd_en = psel && penable && !pwrite && ce;
    logic sw_unpair;
    assign sw_unpair = wr_en && (idx == IDX_CONFIG_FLAGS)
                       && !pwdata[PAIR_BIT];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            paired <= 1'b0;
            paired_id <= 8'h00;
        end else if (ce) begin
            if (do_pair) begin
                paired <= 1'b1;
                paired_id <= held_id;
            end else if (do_unpair || sw_unpair) begin
                paired <= 1'b0;
            end
        end
    end

    logic [EV_W-1:0] events;
    assign events = {frame_bad, do_unpair, do_pair, accept};
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
        end else if (ce) begin
            // status flags; set wins over read clear
            if (rd_en && idx == IDX_SHORT_PRESS) begin
                status <= events;
            end else begin
                status <= status | events;
            end
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask <= '0;
        end else if (wr_en && idx == IDX_IRQ_MASK) begin
            mask <= pwdata[EV_W-1:0];
        end
    end
    assign irq = |(status & mask);

    // display indication timers
    logic [27:0] pair_tmr;
    logic [27:0] unpair_tmr;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pair_tmr <= 28'h0;
            unpair_tmr <= 28'h0;
        end else if (ce) begin
            if (do_pair) begin
                pair_tmr <= 28'(INDICATE_CYC);
                unpair_tmr <= 28'h0;
            end else if (pair_tmr != 28'h0) begin
                pair_tmr <= pair_tmr - 28'h1;
            end
            if (do_unpair) begin
                unpair_tmr <= 28'(INDICATE_CYC);
                pair_tmr <= 28'h0;
            end else if (unpair_tmr != 28'h0 && !do_pair) begin
                unpair_tmr <= unpair_tmr - 28'h1;
            end
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pairing_indication <= 1'b0;
            unpairing_indication <= 1'b0;
        end else if (ce) begin
            pairing_indication <= (pair_tmr != 28'h0);
            unpairing_indication <= (unpair_tmr != 28'h0);
        end
    end

    // read data registered in the setup phase; no wait states
    logic rd_valid;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            rd_valid <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            rd_valid <= psel && penable && !rd_valid;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= 1'b0;
                case (idx)
                    IDX_SHORT_PRESS: prdata <= 32'(status);
                    IDX_REMOTE_CMD: prdata <= 32'(remote_cmd);
                    IDX_CONFIG_FLAGS: prdata <= 32'(paired);
                    IDX_IRQ_MASK: prdata <= 32'(mask);
                    IDX_PAIRED_ID: prdata <= 32'(paired_id);
                    IDX_DISPLAY: prdata <= 32'({unpairing_indication,
                                                pairing_indication});
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign pready = 1'b1;
endmodule : ir_remote_command_receiver

// File: verilog/ir_rx_pkg.sv
// shared constants and types for the infrared command receiver
package ir_rx_pkg;
    // register offsets; printed indices are not all multiples of four
    localparam logic [11:0] IDX_SHORT_PRESS = 12'h001;
    localparam logic [11:0] IDX_REMOTE_CMD = 12'h020;
    localparam logic [11:0] IDX_CONFIG_FLAGS = 12'h0c0;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h0c1;
    localparam logic [11:0] IDX_PAIRED_ID = 12'h0c2;
    localparam logic [11:0] IDX_DISPLAY = 12'h0c3;
    // field positions
    localparam int IR_CMD_BIT = 0;
    localparam int PAIR_BIT = 0;
    // ir frame fields
    localparam int CMD_PAGE_LSB = 11;
    localparam logic [4:0] SUPPORTED_PAGE = 5'h0e;
    // button codes on the id-capable remote
    localparam logic [6:0] KEY_MENU = 7'h01;
    localparam logic [6:0] KEY_RIGHT = 7'h03;
    localparam logic [6:0] KEY_LEFT = 7'h04;
    localparam logic [6:0] KEY_CENTER = 7'h2e;
    // event bits of the short-press status register
    localparam int EV_CMD = 0;
    localparam int EV_PAIR = 1;
    localparam int EV_UNPAIR = 2;
    localparam int EV_BAD = 3;
    localparam int EV_W = 4;
    // timing in microseconds and derived clock counts at 125 MHz
    localparam int CLK_MHZ = 125;
    localparam int LEAD_MARK_MIN_US = 8000;
    localparam int LEAD_SPACE_MIN_US = 3500;
    localparam int REP_SPACE_MAX_US = 3000;
    localparam int BIT_ONE_MIN_US = 1100;
    localparam int GAP_MAX_US = 120000;
    localparam int HOLD_MS = 6000;
    localparam int LEAD_MARK_CYC = LEAD_MARK_MIN_US * CLK_MHZ;
    localparam int LEAD_SPACE_CYC = LEAD_SPACE_MIN_US * CLK_MHZ;
    localparam int REP_SPACE_CYC = REP_SPACE_MAX_US * CLK_MHZ;
    localparam int BIT_ONE_CYC = BIT_ONE_MIN_US * CLK_MHZ;
    localparam int GAP_CYC = GAP_MAX_US * CLK_MHZ;
    // repeats arrive every 108 ms; a 6 s hold is 56 of them
    localparam int REPEAT_MS = 108;
    localparam int HOLD_REPEATS = (HOLD_MS + REPEAT_MS - 1) / REPEAT_MS;
    typedef struct packed {
        logic [7:0] remote_id;
        logic [6:0] button;
    } remote_cmd_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LEAD_MARK = 3'b001,
        ST_LEAD_SPACE = 3'b010,
        ST_BIT_MARK = 3'b011,
        ST_BIT_SPACE = 3'b100,
        ST_STOP = 3'b101
    } rx_state_t;
    function automatic logic [11:0] word_index(input logic [13:0] paddr);
        word_index = paddr[13:2];
    endfunction : word_index
endpackage : ir_rx_pkg
